// ==== stio_pkg.sv ====
// shared constants and types for the status and trigger pin block
package stio_pkg;

  // pin function selection
  localparam logic [1:0] STIO_FN_SPECIAL = 2'h0;  // state indication or trigger
  localparam logic [1:0] STIO_FN_INPUT   = 2'h1;
  localparam logic [1:0] STIO_FN_OUTPUT  = 2'h2;

  // output source selection
  localparam logic [1:0] STIO_SRC_ONE  = 2'h0;
  localparam logic [1:0] STIO_SRC_ZERO = 2'h1;
  localparam logic [1:0] STIO_SRC_PWM  = 2'h2;

  // trigger-in target selection
  localparam logic [1:0] STIO_TGT_METER = 2'h0;
  localparam logic [1:0] STIO_TGT_DLOG  = 2'h1;
  localparam logic [1:0] STIO_TGT_SEQ   = 2'h2;

  // reset values
  localparam logic [1:0] STIO_FN_RESET  = 2'h0;
  localparam logic       STIO_INV_RESET = 1'b0;

  // timing
  localparam int STIO_CLK_HZ        = 20000000;
  localparam int STIO_MIN_LOW_NS    = 30000;
  localparam int STIO_CLK_PERIOD_NS = 1000000000 / STIO_CLK_HZ;
  // least time rounds up
  localparam int STIO_MIN_LOW_CYC   = (STIO_MIN_LOW_NS + STIO_CLK_PERIOD_NS - 1) / STIO_CLK_PERIOD_NS;

  // pwm counter width
  localparam int STIO_PWM_W = 16;

  typedef enum logic [2:0]
  {
    STIO_TX_IDLE = 3'b001,
    STIO_TX_LOW  = 3'b010,
    STIO_TX_GAP  = 3'b100
  } stio_tx_state_type;

endpackage

// ==== stio_pwm.sv ====
// pwm generator with programmable period and high time
module stio_pwm
  import stio_pkg::*;
#(
  parameter int W = STIO_PWM_W
)
(
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] period_i,
  input  wire logic [W-1:0] high_i,
  output logic              pwm_o
);

  logic [W-1:0] cnt_q;
  logic         pwm_q;

  //////////////////////////////////////////////////////////////////////////////
  // free-running period counter; period 0 is treated as one cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cnt_q <= '0;
    else if (cnt_q + W'(1) >= period_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + W'(1);
  end

  // registered output: high while count below the duty threshold
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      pwm_q <= 1'b0;
    else
      pwm_q <= (cnt_q < high_i);
  end

  assign pwm_o = pwm_q;

endmodule

// ==== stio_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
module stio_sync
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;
  logic sync_q;

  //////////////////////////////////////////////////////////////////////////////
  // first stage is read only by the second; reset to idle-high pin level
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// ==== stio_top.sv ====
// state-indicator pin and trigger pin logic of the digital i/o connector
// Operation
// - state pin offers state indication, level input or digital output; indication default
// - trigger pin offers trigger, level input or digital output
// - each pin has polarity; inverted flips both received and driven signals
// - in indication function the state pin follows the output switch
// - normal polarity: high while switch off, low while switch on
// - inverted polarity: low while switch off, high while switch on
// - input function samples the external level and presents it inside
// - output function drives logic one, logic zero or pwm
// - logic one drives low normally, high inverted
// - logic zero drives high normally, low inverted
// - pwm frequency and duty come from two separate settings
// - trigger function works both ways, chosen by out or in sub-mode
// - trigger-out emits a pulse per internal trigger; triggers arriving during a pulse merge into one more pulse
// - trigger-in starts exactly one selected function per received pulse
module stio_top
  import stio_pkg::*;
#(
  parameter int PWM_W   = STIO_PWM_W,
  parameter int LOW_CYC = STIO_MIN_LOW_CYC
)
(
  input  wire logic             CORE_CLK_I,
  input  wire logic             SRST_I,
  // instrument state
  input  wire logic             OUT_ON_I,
  // state-indicator pin configuration
  input  wire logic [1:0]       STAT_FN_I,
  input  wire logic             STAT_INV_I,
  input  wire logic [1:0]       STAT_SRC_I,
  input  wire logic [PWM_W-1:0] STAT_PWM_PERIOD_I,
  input  wire logic [PWM_W-1:0] STAT_PWM_HIGH_I,
  // trigger pin configuration
  input  wire logic [1:0]       TRIG_FN_I,
  input  wire logic             TRIG_INV_I,
  input  wire logic             TRIG_DIR_OUT_I,
  input  wire logic [1:0]       TRIG_TGT_I,
  input  wire logic [1:0]       TRIG_SRC_I,
  input  wire logic [PWM_W-1:0] TRIG_PWM_PERIOD_I,
  input  wire logic [PWM_W-1:0] TRIG_PWM_HIGH_I,
  // internal trigger events, one-cycle pulses
  input  wire logic             MEAS_TRIG_I,
  input  wire logic             DLOG_TRIG_I,
  input  wire logic             SEQ_TRIG_I,
  // state-indicator pin
  input  wire logic             STAT_PIN_I,
  output logic                  STAT_PIN_O,
  output logic                  STAT_PIN_OE_N_O,
  // trigger pin
  input  wire logic             TRIG_PIN_I,
  output logic                  TRIG_PIN_O,
  output logic                  TRIG_PIN_OE_N_O,
  // sampled levels and started functions
  output logic                  STAT_LEVEL_O,
  output logic                  TRIG_LEVEL_O,
  output logic                  MEAS_START_O,
  output logic                  DLOG_START_O,
  output logic                  SEQ_START_O
);

  localparam int CW = $clog2(LOW_CYC + 1);
  localparam logic [CW-1:0] LOW_LAST = CW'(LOW_CYC - 1);

  logic              stat_raw;
  logic              trig_raw;
  logic              stat_pwm;
  logic              trig_pwm;
  logic              stat_pin_d;
  logic              stat_pin_q;
  logic              stat_oe_n_d;
  logic              stat_oe_n_q;
  logic              trig_pin_d;
  logic              trig_pin_q;
  logic              trig_oe_n_d;
  logic              trig_oe_n_q;
  logic              stat_lvl_q;
  logic              trig_lvl_q;
  logic              trig_act;
  logic              trig_act_prev_q;
  logic              trig_fire;
  logic              meas_q;
  logic              dlog_q;
  logic              seq_q;
  logic              int_trig;
  logic              trig_out_mode;
  logic              trig_in_mode;
  stio_tx_state_type tx_state_q;
  logic [CW-1:0]     tx_cnt_q;
  logic              tx_pending_q;

  //////////////////////////////////////////////////////////////////////////////
  // pin inputs cross into the core clock before any logic reads them
  stio_sync u_stat_sync
  (
    .clk_i  (CORE_CLK_I),
    .srst_i (SRST_I),
    .d_i    (STAT_PIN_I),
    .q_o    (stat_raw)
  );

  stio_sync u_trig_sync
  (
    .clk_i  (CORE_CLK_I),
    .srst_i (SRST_I),
    .d_i    (TRIG_PIN_I),
    .q_o    (trig_raw)
  );

  // one pwm source per pin, each with its own frequency and duty
  stio_pwm #(.W(PWM_W)) u_stat_pwm
  (
    .clk_i    (CORE_CLK_I),
    .srst_i   (SRST_I),
    .period_i (STAT_PWM_PERIOD_I),
    .high_i   (STAT_PWM_HIGH_I),
    .pwm_o    (stat_pwm)
  );

  stio_pwm #(.W(PWM_W)) u_trig_pwm
  (
    .clk_i    (CORE_CLK_I),
    .srst_i   (SRST_I),
    .period_i (TRIG_PWM_PERIOD_I),
    .high_i   (TRIG_PWM_HIGH_I),
    .pwm_o    (trig_pwm)
  );

  //////////////////////////////////////////////////////////////////////////////
  // logic one is the active-low level; polarity flips it
  function automatic logic drive_level(input logic [1:0] src, input logic inv, input logic pwm);
    logic lvl;
    lvl = 1'b1;
    if (src == STIO_SRC_ONE)
      lvl = 1'b0;
    else if (src == STIO_SRC_ZERO)
      lvl = 1'b1;
    else if (src == STIO_SRC_PWM)
      lvl = ~pwm;
    return lvl ^ inv;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state-indicator pin drive; oe_n low means the pin is driven
  always_comb
  begin
    stat_pin_d  = 1'b1;
    stat_oe_n_d = 1'b1;
    case (STAT_FN_I)
      STIO_FN_SPECIAL:
      begin
        stat_oe_n_d = 1'b0;
        stat_pin_d  = ~OUT_ON_I ^ STAT_INV_I;
      end
      STIO_FN_OUTPUT:
      begin
        stat_oe_n_d = 1'b0;
        stat_pin_d  = drive_level(STAT_SRC_I, STAT_INV_I, stat_pwm);
      end
      default:
      begin
        stat_oe_n_d = 1'b1;
        stat_pin_d  = 1'b1;
      end
    endcase
  end

  // registered pin outputs; reset state is indication, normal polarity, switch off
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      stat_pin_q  <= 1'b1;
      stat_oe_n_q <= 1'b0;
    end
    else
    begin
      stat_pin_q  <= stat_pin_d;
      stat_oe_n_q <= stat_oe_n_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // polarity-corrected levels seen by the instrument
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      stat_lvl_q <= STIO_INV_RESET;
      trig_lvl_q <= STIO_INV_RESET;
    end
    else
    begin
      stat_lvl_q <= (STAT_FN_I == STIO_FN_INPUT) ? (stat_raw ^ STAT_INV_I) : 1'b0;
      trig_lvl_q <= (TRIG_FN_I == STIO_FN_INPUT) ? (trig_raw ^ TRIG_INV_I) : 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trigger-in: active means low at the pin under normal polarity
  assign trig_out_mode = (TRIG_FN_I == STIO_FN_SPECIAL) && TRIG_DIR_OUT_I;
  assign trig_in_mode  = (TRIG_FN_I == STIO_FN_SPECIAL) && !TRIG_DIR_OUT_I;
  assign trig_act      = ~(trig_raw ^ TRIG_INV_I);
  assign trig_fire     = trig_in_mode && trig_act && !trig_act_prev_q;

  // previous active level for edge detection; starts active so an idle pin gives no false edge after reset
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
      trig_act_prev_q <= 1'b1; // a pin held active at reset gives no event under inverted polarity, one under normal polarity
    else
      trig_act_prev_q <= trig_act;
  end

  // exactly one selected function starts per received edge
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      meas_q <= 1'b0;
      dlog_q <= 1'b0;
      seq_q  <= 1'b0;
    end
    else
    begin
      meas_q <= trig_fire && (TRIG_TGT_I == STIO_TGT_METER);
      dlog_q <= trig_fire && (TRIG_TGT_I == STIO_TGT_DLOG);
      seq_q  <= trig_fire && (TRIG_TGT_I == STIO_TGT_SEQ);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trigger-out pulse shaper: low phase and recovery gap each last the minimum
  // width; triggers arriving mid-pulse are held as one pending pulse, further ones dropped
  assign int_trig = MEAS_TRIG_I || DLOG_TRIG_I || SEQ_TRIG_I;

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      tx_state_q   <= STIO_TX_IDLE;
      tx_cnt_q     <= '0;
      tx_pending_q <= 1'b0;
    end
    else
    begin
      case (tx_state_q)
        STIO_TX_IDLE:
        begin
          tx_cnt_q <= '0;
          if (trig_out_mode && (int_trig || tx_pending_q))
          begin
            tx_state_q   <= STIO_TX_LOW;
            tx_pending_q <= 1'b0;
          end
          else if (!trig_out_mode)
            tx_pending_q <= 1'b0;
        end
        STIO_TX_LOW:
        begin
          if (int_trig)
            tx_pending_q <= 1'b1;
          if (tx_cnt_q == LOW_LAST)
          begin
            tx_state_q <= STIO_TX_GAP;
            tx_cnt_q   <= '0;
          end
          else
            tx_cnt_q <= tx_cnt_q + CW'(1);
        end
        STIO_TX_GAP:
        begin
          if (int_trig)
            tx_pending_q <= 1'b1;
          if (tx_cnt_q == LOW_LAST)
          begin
            tx_state_q <= STIO_TX_IDLE;
            tx_cnt_q   <= '0;
          end
          else
            tx_cnt_q <= tx_cnt_q + CW'(1);
        end
        default:
        begin
          tx_state_q <= STIO_TX_IDLE;
          tx_cnt_q   <= '0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trigger pin drive
  always_comb
  begin
    trig_pin_d  = 1'b1;
    trig_oe_n_d = 1'b1;
    if (trig_out_mode)
    begin
      trig_oe_n_d = 1'b0;
      trig_pin_d  = (tx_state_q != STIO_TX_LOW) ^ TRIG_INV_I;
    end
    else if (TRIG_FN_I == STIO_FN_OUTPUT)
    begin
      trig_oe_n_d = 1'b0;
      trig_pin_d  = drive_level(TRIG_SRC_I, TRIG_INV_I, trig_pwm);
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      trig_pin_q  <= 1'b1;
      trig_oe_n_q <= 1'b1;
    end
    else
    begin
      trig_pin_q  <= trig_pin_d;
      trig_oe_n_q <= trig_oe_n_d;
    end
  end

  assign STAT_PIN_O      = stat_pin_q;
  assign STAT_PIN_OE_N_O = stat_oe_n_q;
  assign TRIG_PIN_O      = trig_pin_q;
  assign TRIG_PIN_OE_N_O = trig_oe_n_q;
  assign STAT_LEVEL_O    = stat_lvl_q;
  assign TRIG_LEVEL_O    = trig_lvl_q;
  assign MEAS_START_O    = meas_q;
  assign DLOG_START_O    = dlog_q;
  assign SEQ_START_O     = seq_q;

endmodule

// ==== stio_ext.sv ====
// far-side instrument model driving and sensing both connector pins
module stio_ext
(
  input  wire logic clk_i,
  input  wire logic stat_o_i,
  input  wire logic stat_oe_n_i,
  input  wire logic trig_o_i,
  input  wire logic trig_oe_n_i,
  output logic      stat_pin_o,
  output logic      trig_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic s_en = 1'b0;
  logic s_lv = 1'b1;
  logic t_en = 1'b0;
  logic t_lv = 1'b1;
  ////////////////////////////////////////////////////////////
  // released lines float up to the pull-up level
  assign stat_pin_o = !stat_oe_n_i ? stat_o_i : (s_en ? s_lv : 1'b1);
  assign trig_pin_o = !trig_oe_n_i ? trig_o_i : (t_en ? t_lv : 1'b1);
  // drive or release both lines
  task automatic drive(input logic se, input logic sl, input logic te, input logic tl);
    s_en = se;
    s_lv = sl;
    t_en = te;
    t_lv = tl;
  endtask
  // active level held n clocks, no shorter than the device needs
  task automatic pulse(input int n, input logic inv);
    t_en = 1'b1;
    t_lv = inv;
    repeat (n) @(posedge clk_i);
    #5 t_lv = !inv;
  endtask
endmodule

// ==== stio_top_checker.sv ====
// concurrent checks on the pin block ports
module stio_top_checker
  import stio_pkg::*;
#(
  parameter int LOW_CYC = STIO_MIN_LOW_CYC
)
(
  input wire logic       CORE_CLK_I,
  input wire logic       SRST_I,
  input wire logic       OUT_ON_I,
  input wire logic [1:0] STAT_FN_I,
  input wire logic       STAT_INV_I,
  input wire logic [1:0] STAT_SRC_I,
  input wire logic [1:0] TRIG_FN_I,
  input wire logic       TRIG_INV_I,
  input wire logic       TRIG_DIR_OUT_I,
  input wire logic [1:0] TRIG_TGT_I,
  input wire logic [1:0] TRIG_SRC_I,
  input wire logic       STAT_PIN_I,
  input wire logic       STAT_PIN_O,
  input wire logic       STAT_PIN_OE_N_O,
  input wire logic       TRIG_PIN_I,
  input wire logic       TRIG_PIN_O,
  input wire logic       STAT_LEVEL_O,
  input wire logic       MEAS_START_O,
  input wire logic       DLOG_START_O,
  input wire logic       SEQ_START_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  ////////////////////////////////////////////////////////////
  wire logic tout = TRIG_FN_I == STIO_FN_SPECIAL && TRIG_DIR_OUT_I && !TRIG_INV_I;
  wire logic strt = MEAS_START_O || DLOG_START_O || SEQ_START_O;
  logic [15:0] low_q;
  // low run length, counted only for lows that began in trigger-out
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I || !tout || TRIG_PIN_O || (low_q == 16'h0 && !$past(TRIG_PIN_O)))
      low_q <= 16'h0;
    else
      low_q <= low_q + 16'h1;
  end
  property p_ind;
    !$past(SRST_I) && $past(STAT_FN_I) == STIO_FN_SPECIAL |->
      STAT_PIN_O == (!$past(OUT_ON_I) ^ $past(STAT_INV_I)) && !STAT_PIN_OE_N_O;
  endproperty
  a_ind: assert property (p_ind) else $error("state pin wrong in indication");
  property p_one;
    !$past(SRST_I) && $past(STAT_FN_I) == STIO_FN_OUTPUT && $past(STAT_SRC_I) == STIO_SRC_ONE |->
      STAT_PIN_O == $past(STAT_INV_I);
  endproperty
  a_one: assert property (p_one) else $error("logic one level wrong");
  property p_zero;
    !$past(SRST_I) && $past(TRIG_FN_I) == STIO_FN_OUTPUT && $past(TRIG_SRC_I) == STIO_SRC_ZERO |->
      TRIG_PIN_O == !$past(TRIG_INV_I);
  endproperty
  a_zero: assert property (p_zero) else $error("logic zero level wrong");
  property p_tri;
    !$past(SRST_I) && $past(STAT_FN_I) == STIO_FN_INPUT |-> STAT_PIN_OE_N_O;
  endproperty
  a_tri: assert property (p_tri) else $error("state pin driven in input");
  property p_lvl;
    (STAT_FN_I == STIO_FN_INPUT && $stable(STAT_PIN_I) && $stable(STAT_INV_I))[*5] |->
      STAT_LEVEL_O == (STAT_PIN_I ^ STAT_INV_I);
  endproperty
  a_lvl: assert property (p_lvl) else $error("sampled level wrong");
  property p_once;
    strt |-> $onehot({MEAS_START_O, DLOG_START_O, SEQ_START_O}) ##1 !strt;
  endproperty
  a_once: assert property (p_once) else $error("start not a single pulse");
  property p_tin;
    TRIG_FN_I == STIO_FN_SPECIAL && !TRIG_DIR_OUT_I && !TRIG_INV_I &&
      TRIG_TGT_I == STIO_TGT_METER && $fell(TRIG_PIN_I) |-> ##[2:4] MEAS_START_O;
  endproperty
  a_tin: assert property (p_tin) else $error("trigger edge gave no start");
  property p_tlow;
    tout && low_q != 16'h0 && $rose(TRIG_PIN_O) |-> low_q >= LOW_CYC;
  endproperty
  a_tlow: assert property (p_tlow) else $error("emitted pulse too short");
endmodule
bind stio_top stio_top_checker #(.LOW_CYC(LOW_CYC)) i_stio_top_checker (.*);

// ==== status_trigger_io_pins_bench.sv ====
// self-checking bench for the status and trigger pin block
module status_trigger_io_pins_bench
  import stio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOW = 4; // short pulse keeps the run brief
  logic CORE_CLK_I = 1'b0, SRST_I = 1'b1, OUT_ON_I = 1'b0, STAT_INV_I = 1'b0, TRIG_INV_I = 1'b0;
  logic TRIG_DIR_OUT_I = 1'b0, MEAS_TRIG_I = 1'b0, DLOG_TRIG_I = 1'b0, SEQ_TRIG_I = 1'b0;
  logic [1:0] STAT_FN_I = 2'h0, STAT_SRC_I = 2'h0, TRIG_FN_I = 2'h0, TRIG_TGT_I = 2'h0, TRIG_SRC_I = 2'h0;
  logic [15:0] STAT_PWM_PERIOD_I = 16'h0, STAT_PWM_HIGH_I = 16'h0, TRIG_PWM_PERIOD_I = 16'h0;
  logic [15:0] TRIG_PWM_HIGH_I = 16'h0;
  logic STAT_PIN_I, TRIG_PIN_I, STAT_PIN_O, STAT_PIN_OE_N_O, TRIG_PIN_O, TRIG_PIN_OE_N_O;
  logic STAT_LEVEL_O, TRIG_LEVEL_O, MEAS_START_O, DLOG_START_O, SEQ_START_O;
  int err_total = 0, n_tests = 0, c0, c1, c2, cf, cl, cs;
  logic [15:0] p, h;
  ////////////////////////////////////////////////////////////
  stio_top #(.LOW_CYC(LOW)) i_stio_top (.*);
  stio_ext i_stio_ext (.clk_i(CORE_CLK_I), .stat_o_i(STAT_PIN_O), .stat_oe_n_i(STAT_PIN_OE_N_O),
    .trig_o_i(TRIG_PIN_O), .trig_oe_n_i(TRIG_PIN_OE_N_O), .stat_pin_o(STAT_PIN_I), .trig_pin_o(TRIG_PIN_I));
  // free-running 20 MHz clock
  initial
  begin
    forever #25 CORE_CLK_I = !CORE_CLK_I;
  end
  function automatic logic f_lvl(input logic a, input logic inv);
    return a ^ inv; // driven or received level after polarity
  endfunction
  task automatic tk(input int n);
    repeat (n) @(posedge CORE_CLK_I);
    #5;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // counts sampled mid-cycle, away from the updating edge
  task automatic watch(input int n);
    logic q;
    {c0, c1, c2, cf, cl, cs} = '0;
    q = TRIG_PIN_O;
    repeat (n)
    begin
      @(negedge CORE_CLK_I);
      c0 += MEAS_START_O;
      c1 += DLOG_START_O;
      c2 += SEQ_START_O;
      cf += q && !TRIG_PIN_O;
      cl += !TRIG_PIN_O;
      cs += !STAT_PIN_O;
      q = TRIG_PIN_O;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog sized well past the planned sequence
  initial
  begin
    tk(20000);
    err_total++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    void'($urandom(4));
    tk(2);
    chk("reset_pins", 16'h5, {STAT_PIN_O, STAT_PIN_OE_N_O, TRIG_PIN_OE_N_O});
    SRST_I = 1'b0;
    $display("test reset done");
    repeat (16)
    begin
      OUT_ON_I = 1'($urandom);
      STAT_INV_I = 1'($urandom);
      tk(3);
      chk("stat_ind", f_lvl(!OUT_ON_I, STAT_INV_I), STAT_PIN_O);
    end
    $display("test indication done");
    {STAT_FN_I, TRIG_FN_I} = {STIO_FN_OUTPUT, STIO_FN_OUTPUT};
    for (int i = 0; i < 4; i++)
    begin
      STAT_SRC_I = i[0] ? STIO_SRC_ZERO : STIO_SRC_ONE;
      TRIG_SRC_I = STAT_SRC_I;
      {STAT_INV_I, TRIG_INV_I} = {2{i[1]}};
      tk(3);
      chk("out_pins", {2{f_lvl(i[0], i[1])}}, {STAT_PIN_O, TRIG_PIN_O});
      chk("out_oe_n", 16'h0, {STAT_PIN_OE_N_O, TRIG_PIN_OE_N_O});
    end
    {STAT_SRC_I, TRIG_SRC_I, STAT_INV_I, TRIG_INV_I} = {STIO_SRC_PWM, STIO_SRC_PWM, 2'h0};
    repeat (2)
    begin
      p = 16'(4 + $urandom % 13);
      h = 16'($urandom % (p + 1));
      {STAT_PWM_PERIOD_I, STAT_PWM_HIGH_I, TRIG_PWM_PERIOD_I, TRIG_PWM_HIGH_I} = {p, h, p, h};
      tk(2 * p + 6);
      watch(4 * p);
      chk("pwm_low", 16'(4 * h), 16'(cs));
      chk("pwm_low_t", 16'(4 * h), 16'(cl));
    end
    $display("test output done");
    {STAT_FN_I, TRIG_FN_I} = {STIO_FN_INPUT, STIO_FN_INPUT};
    repeat (8)
    begin
      {STAT_INV_I, TRIG_INV_I} = 2'($urandom);
      p = 16'($urandom);
      i_stio_ext.drive(1'b1, p[0], 1'b1, p[1]);
      tk(6);
      chk("in_levels", {f_lvl(p[0], STAT_INV_I), f_lvl(p[1], TRIG_INV_I)}, {STAT_LEVEL_O, TRIG_LEVEL_O});
      chk("in_oe_n", 16'h3, {STAT_PIN_OE_N_O, TRIG_PIN_OE_N_O});
    end
    $display("test input done");
    {TRIG_FN_I, TRIG_DIR_OUT_I} = {STIO_FN_SPECIAL, 1'b0};
    for (int i = 0; i < 6; i++)
    begin
      TRIG_TGT_I = 2'(i % 3);
      TRIG_INV_I = i > 2;
      i_stio_ext.drive(1'b0, 1'b1, 1'b1, !TRIG_INV_I);
      tk(8);
      fork
        i_stio_ext.pulse(LOW, TRIG_INV_I);
        watch(LOW + 10);
      join
      chk("starts", 16'(1 << (2 * (i % 3))), 16'({c2[1:0], c1[1:0], c0[1:0]}));
    end
    $display("test trigger in done");
    i_stio_ext.drive(1'b0, 1'b1, 1'b0, 1'b1);
    {TRIG_DIR_OUT_I, TRIG_INV_I} = 2'h2;
    tk(2 * LOW + 6);
    fork
      begin
        MEAS_TRIG_I = 1'b1;
        tk(1);
        {MEAS_TRIG_I, DLOG_TRIG_I} = 2'h1;
        tk(1);
        {DLOG_TRIG_I, SEQ_TRIG_I} = 2'h1;
        tk(1);
        SEQ_TRIG_I = 1'b0;
      end
      watch(5 * LOW + 10);
    join
    chk("tout_pulses", 16'h2, 16'(cf));
    chk("tout_low", 16'(2 * LOW), 16'(cl));
    $display("test trigger out done");
    // reset again mid-run: state pin back to driven indication default, trigger pin released, levels and starts cleared
    SRST_I = 1'b1;
    tk(2);
    chk("reset_again_pins", 16'hB, {STAT_PIN_O, STAT_PIN_OE_N_O, TRIG_PIN_O, TRIG_PIN_OE_N_O});
    chk("reset_again_out", 16'h0, {STAT_LEVEL_O, TRIG_LEVEL_O, MEAS_START_O, DLOG_START_O, SEQ_START_O});
    SRST_I = 1'b0;
    tk(2);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
